// ==== inc/lbx_pkg.sv ====
// constants, opcode fields and operation codes for the logic and bit-op executor
// assumes 14-bit instruction words and an 8-bit data path
package lbx_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned BIT_W   = 3;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned OP6_MSB   = 13;
  localparam int unsigned OP6_LSB   = 8;
  localparam int unsigned OP5_LSB   = 9;
  localparam int unsigned DEST_POS  = 7;
  localparam int unsigned BIT_MSB   = 8;
  localparam int unsigned BIT_LSB   = 6;
  localparam int unsigned BADDR_MSB = 5;
  localparam int unsigned LIT_MSB   = 7;

  // ****************************************************************
  // opcodes
  // ****************************************************************
  localparam logic [5:0] OPC_AND_LIT  = 6'h1b;
  localparam logic [5:0] OPC_AND_FILE = 6'h05;
  localparam logic [4:0] OPC_BIT_CLR  = 5'h08;
  localparam logic [4:0] OPC_BIT_SET  = 5'h09;
  localparam logic [4:0] OPC_SKIP_LO  = 5'h0a;
  localparam logic [4:0] OPC_SKIP_HI  = 5'h0b;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] ACC_RESET  = 8'h00;
  localparam logic       ZERO_RESET = 1'b0;

  typedef enum logic [2:0] {
    OP_IDLE_INSTRUCTION,
    OP_AND_LITERAL_INTO_ACCUMULATOR,
    OP_AND_ACCUMULATOR_WITH_FILE,
    OP_BIT_CLEAR_IN_FILE,
    OP_BIT_SET_IN_FILE,
    OP_TEST_BIT_SKIP_WHEN_LOW,
    OP_TEST_BIT_SKIP_WHEN_HIGH
  } lbx_op_e;

endpackage

// ==== logic/lbx_decode.sv ====
// instruction field decoder for the logic and bit-op executor
// assumes a stable instruction word; purely combinational
`timescale 1ns/10ps
`default_nettype none

module lbx_decode (
  input  wire logic [13:0]    instr_word,
  output var  lbx_pkg::lbx_op_e op,
  output logic      [6:0]     file_addr,
  output logic      [2:0]     bit_sel,
  output logic      [7:0]     literal,
  output logic                dest_file
);

  logic [5:0] op6;
  logic [4:0] op5;

  assign op6     = instr_word[lbx_pkg::OP6_MSB:lbx_pkg::OP6_LSB];
  assign op5     = instr_word[lbx_pkg::OP6_MSB:lbx_pkg::OP5_LSB];
  assign bit_sel = instr_word[lbx_pkg::BIT_MSB:lbx_pkg::BIT_LSB];
  assign literal = instr_word[lbx_pkg::LIT_MSB:0];
  assign dest_file = instr_word[lbx_pkg::DEST_POS];

  always_comb begin
    op        = lbx_pkg::OP_IDLE_INSTRUCTION;
    file_addr = instr_word[6:0];
    if (op6 == lbx_pkg::OPC_AND_LIT) begin
      op = lbx_pkg::OP_AND_LITERAL_INTO_ACCUMULATOR;
    end else if (op6 == lbx_pkg::OPC_AND_FILE) begin
      op = lbx_pkg::OP_AND_ACCUMULATOR_WITH_FILE;
    end else begin
      // bit ops reach only the low 64 file locations
      file_addr = {1'b0, instr_word[lbx_pkg::BADDR_MSB:0]};
      case (op5)
        lbx_pkg::OPC_BIT_CLR: op = lbx_pkg::OP_BIT_CLEAR_IN_FILE;
        lbx_pkg::OPC_BIT_SET: op = lbx_pkg::OP_BIT_SET_IN_FILE;
        lbx_pkg::OPC_SKIP_LO: op = lbx_pkg::OP_TEST_BIT_SKIP_WHEN_LOW;
        lbx_pkg::OPC_SKIP_HI: op = lbx_pkg::OP_TEST_BIT_SKIP_WHEN_HIGH;
        default:              op = lbx_pkg::OP_IDLE_INSTRUCTION;
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== logic/lbx_exec.sv ====
// executor for the and, bit clear/set and bit test-and-skip instructions
// assumes the file space answers file_rd_data combinationally for file_addr
// and commits file_wr_* at the clock edge where file_wr_en_q is high
`timescale 1ns/10ps
`default_nettype none

module lbx_exec (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       instr_valid,
  input  wire logic [13:0] instr_word,
  input  wire logic [7:0] file_rd_data,
  input  wire logic       acc_load_en,
  input  wire logic [7:0] acc_load_data,
  output logic      [6:0] file_addr,
  output logic            file_wr_en_q,
  output logic      [6:0] file_wr_addr_q,
  output logic      [7:0] file_wr_data_q,
  output logic      [7:0] acc_q,
  output logic            zero_q,
  output logic            skip_pending_q,
  output logic            squashed_q,
  output logic            instr_done_q
);

  // ****************************************************************
  // decode
  // ****************************************************************
  lbx_pkg::lbx_op_e op;
  logic [2:0]       bit_sel;
  logic [7:0]       literal;
  logic             dest_file;
  logic [7:0]       operand;
  logic             tested_bit;
  logic             exec;

  lbx_decode u_decode (
    .instr_word (instr_word),
    .op         (op),
    .file_addr  (file_addr),
    .bit_sel    (bit_sel),
    .literal    (literal),
    .dest_file  (dest_file)
  );

  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  // a write still in flight must be seen by the very next instruction
  assign operand = (file_wr_en_q && (file_wr_addr_q == file_addr)) ? file_wr_data_q
                                                                   : file_rd_data;
  assign tested_bit = operand[bit_sel];
  assign exec       = instr_valid && !skip_pending_q;

  // ****************************************************************
  // execute
  // ****************************************************************
  logic [7:0] acc_d;
  logic       zero_d;
  logic       wr_en_d;
  logic [6:0] wr_addr_d;
  logic [7:0] wr_data_d;
  logic       skip_d;
  logic       squash_d;
  logic       done_d;
  logic [7:0] and_res;

  always_comb begin
    acc_d     = acc_q;
    zero_d    = zero_q;
    wr_en_d   = 1'b0;
    wr_addr_d = file_addr;
    wr_data_d = file_wr_data_q;
    skip_d    = skip_pending_q;
    squash_d  = 1'b0;
    done_d    = 1'b0;
    and_res   = acc_q & operand;
    if (instr_valid && skip_pending_q) begin
      // discarded word runs as an idle slot: the second test cycle
      skip_d   = 1'b0;
      squash_d = 1'b1;
    end else if (exec) begin
      done_d = 1'b1;
      case (op)
        lbx_pkg::OP_AND_LITERAL_INTO_ACCUMULATOR: begin
          acc_d  = acc_q & literal;
          zero_d = ((acc_q & literal) == 8'h00);
        end
        lbx_pkg::OP_AND_ACCUMULATOR_WITH_FILE: begin
          zero_d = (and_res == 8'h00);
          if (dest_file) begin
            wr_en_d   = 1'b1;
            wr_data_d = and_res;
          end else begin
            acc_d = and_res;
          end
        end
        lbx_pkg::OP_BIT_CLEAR_IN_FILE: begin
          wr_en_d   = 1'b1;
          wr_data_d = operand & ~bit_mask(bit_sel);
        end
        lbx_pkg::OP_BIT_SET_IN_FILE: begin
          wr_en_d   = 1'b1;
          wr_data_d = operand | bit_mask(bit_sel);
        end
        lbx_pkg::OP_TEST_BIT_SKIP_WHEN_LOW: begin
          skip_d = !tested_bit;
        end
        lbx_pkg::OP_TEST_BIT_SKIP_WHEN_HIGH: begin
          skip_d = tested_bit;
        end
        default: begin
        end
      endcase
    end else if (!instr_valid && acc_load_en) begin
      // the rest of the core loads the accumulator only between our words
      acc_d = acc_load_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acc_q          <= lbx_pkg::ACC_RESET;
      zero_q         <= lbx_pkg::ZERO_RESET;
      file_wr_en_q   <= 1'b0;
      file_wr_addr_q <= 7'h00;
      file_wr_data_q <= 8'h00;
      skip_pending_q <= 1'b0;
      squashed_q     <= 1'b0;
      instr_done_q   <= 1'b0;
    end else begin
      acc_q          <= acc_d;
      zero_q         <= zero_d;
      file_wr_en_q   <= wr_en_d;
      file_wr_addr_q <= wr_addr_d;
      file_wr_data_q <= wr_data_d;
      skip_pending_q <= skip_d;
      squashed_q     <= squash_d;
      instr_done_q   <= done_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence s_exec_op(lbx_pkg::lbx_op_e o);
    exec && op == o;
  endsequence

  sequence s_skip_armed;
    (exec && op == lbx_pkg::OP_TEST_BIT_SKIP_WHEN_LOW && !tested_bit) ||
    (exec && op == lbx_pkg::OP_TEST_BIT_SKIP_WHEN_HIGH && tested_bit);
  endsequence

  property p_and_lit;
    s_exec_op(lbx_pkg::OP_AND_LITERAL_INTO_ACCUMULATOR) |=>
      acc_q == ($past(acc_q) & $past(literal)) && instr_done_q;
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("literal and result wrong");

  property p_and_lit_only_acc;
    s_exec_op(lbx_pkg::OP_AND_LITERAL_INTO_ACCUMULATOR) |=> !file_wr_en_q && !skip_pending_q;
  endproperty
  a_and_lit_only_acc: assert property (p_and_lit_only_acc) else $error("literal and side effect");

  property p_and_file_addr;
    s_exec_op(lbx_pkg::OP_AND_ACCUMULATOR_WITH_FILE) |-> file_addr == instr_word[6:0];
  endproperty
  a_and_file_addr: assert property (p_and_file_addr) else $error("file and address wrong");

  property p_and_to_acc;
    s_exec_op(lbx_pkg::OP_AND_ACCUMULATOR_WITH_FILE) ##0 !dest_file |=>
      acc_q == ($past(acc_q) & $past(operand)) && !file_wr_en_q;
  endproperty
  a_and_to_acc: assert property (p_and_to_acc) else $error("and to accumulator wrong");

  property p_and_to_file;
    s_exec_op(lbx_pkg::OP_AND_ACCUMULATOR_WITH_FILE) ##0 dest_file |=>
      file_wr_en_q && file_wr_data_q == ($past(acc_q) & $past(operand)) && $stable(acc_q);
  endproperty
  a_and_to_file: assert property (p_and_to_file) else $error("and to file wrong");

  property p_bit_addr;
    exec && op inside {lbx_pkg::OP_BIT_CLEAR_IN_FILE, lbx_pkg::OP_BIT_SET_IN_FILE} |=>
      file_wr_addr_q == {1'b0, $past(instr_word[5:0])};
  endproperty
  a_bit_addr: assert property (p_bit_addr) else $error("bit op address wrong");

  property p_bit_clr;
    s_exec_op(lbx_pkg::OP_BIT_CLEAR_IN_FILE) |=> file_wr_en_q &&
      file_wr_data_q == ($past(operand) & ~(8'h01 << $past(bit_sel))) && $stable(zero_q);
  endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("bit clear wrong");

  property p_bit_set;
    s_exec_op(lbx_pkg::OP_BIT_SET_IN_FILE) |=> file_wr_en_q &&
      file_wr_data_q == ($past(operand) | (8'h01 << $past(bit_sel))) && $stable(zero_q);
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

  property p_skip_low;
    s_exec_op(lbx_pkg::OP_TEST_BIT_SKIP_WHEN_LOW) |=> skip_pending_q == !$past(tested_bit);
  endproperty
  a_skip_low: assert property (p_skip_low) else $error("skip when low wrong");

  property p_skip_high;
    s_exec_op(lbx_pkg::OP_TEST_BIT_SKIP_WHEN_HIGH) |=> skip_pending_q == $past(tested_bit);
  endproperty
  a_skip_high: assert property (p_skip_high) else $error("skip when high wrong");

  // the discarded word must leave accumulator and flag alone as well
  property p_skip_slot;
    s_skip_armed ##1 instr_valid |=>
      squashed_q && !instr_done_q && !file_wr_en_q && !skip_pending_q && $stable(zero_q) &&
      $stable(acc_q);
  endproperty
  a_skip_slot: assert property (p_skip_slot) else $error("skip slot wrong");

  property p_zero_flag;
    exec && op inside {lbx_pkg::OP_AND_LITERAL_INTO_ACCUMULATOR,
                       lbx_pkg::OP_AND_ACCUMULATOR_WITH_FILE} |=>
      zero_q == (($past(acc_q) &
      (($past(op) == lbx_pkg::OP_AND_LITERAL_INTO_ACCUMULATOR) ? $past(literal)
       : $past(operand))) == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

endmodule

`default_nettype wire

// ==== tb/lbx_file_model.sv ====
// file register space model sitting beside the executor
// assumes writes commit on the edge where file_wr_en_q is high
`timescale 1ns/10ps
`default_nettype none

module lbx_file_model (
  input  wire logic       sys_clk,
  input  wire logic [6:0] file_addr,
  input  wire logic       file_wr_en_q,
  input  wire logic [6:0] file_wr_addr_q,
  input  wire logic [7:0] file_wr_data_q,
  input  wire logic       pre_en,
  input  wire logic [6:0] pre_addr,
  input  wire logic [7:0] pre_data,
  output logic      [7:0] file_rd_data
);
  logic [7:0] mem [128];

  assign file_rd_data = mem[file_addr];

  // core write wins; bench preloads only while the core is quiet
  always @(posedge sys_clk) begin
    if (file_wr_en_q) begin
      mem[file_wr_addr_q] <= file_wr_data_q;
    end else if (pre_en) begin
      mem[pre_addr] <= pre_data;
    end
  end
endmodule

`default_nettype wire

// ==== tb/logic_and_bit_ops_exec_tb.sv ====
// self-checking bench for lbx_exec with a file space model
// assumes inputs change on the falling edge, results read there too
`timescale 1ns/10ps
`default_nettype none

module logic_and_bit_ops_exec_tb;
  typedef struct {
    logic       sq;
    logic       wen;
    logic [6:0] wa;
    logic [7:0] wd;
    logic [7:0] acc;
    logic       z;
    logic       sk;
  } lbx_exp_s;

  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        instr_valid = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic        acc_load_en = 1'b0;
  logic [7:0]  acc_load_data = 8'h00;
  logic        pre_en = 1'b0;
  logic [6:0]  pre_addr = 7'h00;
  logic [7:0]  pre_data = 8'h00;
  logic [7:0]  file_rd_data, file_wr_data_q, acc_q;
  logic [6:0]  file_addr, file_wr_addr_q;
  logic        file_wr_en_q, zero_q, skip_pending_q, squashed_q, instr_done_q;
  logic [7:0]  m_acc = 8'h00;
  logic        m_z = 1'b0;
  logic        m_skip = 1'b0;
  logic [7:0]  m_mem [128];
  lbx_exp_s    expq [$];
  lbx_exp_s    got_e;
  int          mismatches = 0;
  int          n_checks = 0;

  always #50 sys_clk = ~sys_clk;

  lbx_exec uut (.sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid),
    .instr_word(instr_word), .file_rd_data(file_rd_data), .acc_load_en(acc_load_en),
    .acc_load_data(acc_load_data), .file_addr(file_addr), .file_wr_en_q(file_wr_en_q),
    .file_wr_addr_q(file_wr_addr_q), .file_wr_data_q(file_wr_data_q), .acc_q(acc_q),
    .zero_q(zero_q), .skip_pending_q(skip_pending_q), .squashed_q(squashed_q),
    .instr_done_q(instr_done_q));

  lbx_file_model mdl (.sys_clk(sys_clk), .file_addr(file_addr), .file_wr_en_q(file_wr_en_q),
    .file_wr_addr_q(file_wr_addr_q), .file_wr_data_q(file_wr_data_q), .pre_en(pre_en),
    .pre_addr(pre_addr), .pre_data(pre_data), .file_rd_data(file_rd_data));

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_checks++;
    if (got !== ex) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // every task that drives goes through drive, which sets every input but reset, so nothing lingers from the last call
  task automatic drive(input logic v, input logic [13:0] w, input logic ld, input logic [7:0] d,
                       input logic pe, input logic [6:0] pa);
    @(negedge sys_clk);
    instr_valid = v;
    instr_word = w;
    acc_load_en = ld;
    acc_load_data = d;
    pre_en = pe;
    pre_addr = pa;
    pre_data = d;
  endtask

  task automatic idle(input int n);
    repeat (n) drive(1'b0, 14'h0000, 1'b0, 8'h00, 1'b0, 7'h00);
  endtask

  task automatic load(input logic [7:0] d);
    drive(1'b0, 14'h0000, 1'b1, d, 1'b0, 7'h00);
    m_acc = d;
  endtask

  // load request beside a valid word must be ignored
  task automatic exec(input logic [13:0] w);
    lbx_exp_s   e;
    logic [7:0] r;
    logic [6:0] a;
    drive(1'b1, w, 1'($urandom), 8'($urandom), 1'b0, 7'h00);
    e = '{sq: m_skip, wen: 1'b0, wa: 7'h00, wd: 8'h00, acc: 8'h00, z: 1'b0, sk: 1'b0};
    a = w[6:0];
    if (m_skip) m_skip = 1'b0;
    else if (w[13:8] == lbx_pkg::OPC_AND_LIT) begin
      m_acc = m_acc & w[7:0];
      m_z = (m_acc == 8'h00);
    end else if (w[13:8] == lbx_pkg::OPC_AND_FILE) begin
      r = m_acc & m_mem[a];
      m_z = (r == 8'h00);
      if (w[7]) e = '{sq: 1'b0, wen: 1'b1, wa: a, wd: r, acc: 8'h00, z: 1'b0, sk: 1'b0};
      else m_acc = r;
    end else if (w[13:10] == 4'h4) begin
      a = {1'b0, w[5:0]};
      r = m_mem[a];
      r[w[8:6]] = w[9];
      e = '{sq: 1'b0, wen: 1'b1, wa: a, wd: r, acc: 8'h00, z: 1'b0, sk: 1'b0};
    end else if (w[13:9] == lbx_pkg::OPC_SKIP_LO) m_skip = !m_mem[{1'b0, w[5:0]}][w[8:6]];
    else if (w[13:9] == lbx_pkg::OPC_SKIP_HI) m_skip = m_mem[{1'b0, w[5:0]}][w[8:6]];
    if (e.wen) m_mem[e.wa] = e.wd;
    e.acc = m_acc;
    e.z = m_z;
    e.sk = m_skip;
    expq.push_back(e);
  endtask

  always @(negedge sys_clk) begin
    if (!reset && (instr_done_q !== 1'b0 || squashed_q !== 1'b0)) begin
      if (expq.size() == 0) chk("unexpected result", 8'h00, 8'h01);
      else begin
        got_e = expq.pop_front();
        chk("squashed", 8'(got_e.sq), 8'(squashed_q));
        chk("done", 8'(!got_e.sq), 8'(instr_done_q));
        chk("acc", got_e.acc, acc_q);
        chk("zero", 8'(got_e.z), 8'(zero_q));
        chk("wr_en", 8'(got_e.wen), 8'(file_wr_en_q));
        chk("skip", 8'(got_e.sk), 8'(skip_pending_q));
        if (got_e.wen) begin
          chk("wr_addr", 8'(got_e.wa), 8'(file_wr_addr_q));
          chk("wr_data", got_e.wd, file_wr_data_q);
        end
      end
    end
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    $display("watchdog expired");
    stop_test;
  end

  initial begin
    void'($urandom(78));
    repeat (12) @(negedge sys_clk);
    reset = 1'b0;
    chk("acc after reset", lbx_pkg::ACC_RESET, acc_q);
    chk("zero after reset", 8'(lbx_pkg::ZERO_RESET), 8'(zero_q));
    for (int i = 0; i < 128; i++) begin
      drive(1'b0, 14'h0000, 1'b0, (i == 4) ? 8'hc2 : 8'($urandom), 1'b1, 7'(i));
      m_mem[i] = pre_data;
    end
    load(8'ha3);
    exec(14'h1b5f);
    exec(14'h1b00);
    exec(14'h1bff);
    $display("test and_literal done");
    load(8'h17);
    exec(14'h0584);
    exec(14'h0504);
    exec(14'h05ff);
    $display("test and_file done");
    for (int b = 0; b < 8; b++) begin
      exec({lbx_pkg::OPC_BIT_CLR, 3'(b), 6'h3f});
      exec({lbx_pkg::OPC_BIT_SET, 3'(b), 6'h3f});
      exec({lbx_pkg::OPC_SKIP_LO, 3'(b), 6'h3f});
      exec({lbx_pkg::OPC_SKIP_HI, 3'(b), 6'h3f});
      exec({lbx_pkg::OPC_BIT_CLR, 3'(b), 6'h3f});
      exec({lbx_pkg::OPC_SKIP_LO, 3'(b), 6'h3f});
      idle(2);
      exec(14'h1b00);
    end
    $display("test bit_ops done");
    // a reset in mid-run must drop a pending skip
    exec({lbx_pkg::OPC_SKIP_HI, 3'h0, 6'h3f});
    idle(1);
    @(negedge sys_clk);
    reset = 1'b1;
    idle(2);
    reset = 1'b0;
    m_acc = lbx_pkg::ACC_RESET;
    m_z = lbx_pkg::ZERO_RESET;
    m_skip = 1'b0;
    chk("acc after reset", lbx_pkg::ACC_RESET, acc_q);
    chk("skip after reset", 8'h00, 8'(skip_pending_q));
    exec(14'h1bff);
    $display("test mid_reset done");
    for (int i = 0; i < 400; i++) begin
      case ($urandom % 5)
        0: exec(14'($urandom));
        1: exec({6'h1b, 8'($urandom)});
        2: exec({6'h05, 8'($urandom)});
        3: load(8'($urandom));
        default: exec({3'b010, 11'($urandom)});
      endcase
    end
    idle(3);
    chk("queue left", 8'h00, 8'(expq.size()));
    $display("test random done");
    stop_test;
  end
endmodule

`default_nettype wire
